// ### design/fast_reset_pkg.sv
/*
  Package for the fast CPU reset and address-gate block: register offsets,
  field positions, reset values, timing constants and carrier structs.
  Assumes a 20 MHz system clock and an 8-bit register port.
*/
package fast_reset_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] FAST_CTRL_OFFSET    = 8'h92;
  localparam logic [7:0] GATE_CONFIG_OFFSET  = 8'hF0;
  localparam logic [7:0] FAST_CTRL_RESET     = 8'h24;
  localparam logic [7:0] GATE_CONFIG_RESET   = 8'h00;
  // fixed read pattern of the reserved bits of the fast control register
  localparam logic [7:0] FAST_CTRL_FIXED     = 8'h24;
  localparam logic [7:0] FAST_CTRL_LIVE_MASK = 8'h03;
  localparam logic [7:0] READ_ZERO           = 8'h00;

  // field positions
  localparam int RESET_BIT_POS     = 0;
  localparam int GATE_BIT_POS      = 1;
  localparam int PORT_ENABLE_POS   = 2;
  localparam int KBD_LATCH_SEL_POS = 3;
  localparam int MOUSE_LATCH_POS   = 4;
  localparam int RESET_POL_POS     = 5;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  // both printed sets of minimums are met by taking the longer of each
  localparam int DELAY_TABLE_NS = 500;
  localparam int DELAY_TEXT_US  = 14;
  localparam int PULSE_TABLE_US = 1;
  localparam int PULSE_TEXT_US  = 6;
  localparam int DELAY_NS = (DELAY_TEXT_US * 1000 > DELAY_TABLE_NS) ?
                            DELAY_TEXT_US * 1000 : DELAY_TABLE_NS;
  localparam int PULSE_NS = ((PULSE_TEXT_US > PULSE_TABLE_US) ?
                             PULSE_TEXT_US : PULSE_TABLE_US) * 1000;
  // least times round up to whole cycles
  localparam int DELAY_CYCLES = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic kbd_irq;
    logic mouse_irq;
  } irq_pair_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_PULSE = 2'b11,
    ST_HOLD  = 2'b10
  } pulse_state_t;

endpackage

// ### design/irq_latch.sv
/*
  Interrupt latch for one controller interrupt line with a select bit.
  Assumes the raw interrupt is synchronous to the system clock.
*/
`timescale 1ns/1ps
module irq_latch (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // raw interrupt and select
  input  wire logic i_raw,
  input  wire logic i_latch_only,
  // shaped interrupt, registered
  output logic      o_irq
);

  logic raw_d_reg;
  logic raw_d_next;
  logic held_reg;
  logic held_next;
  logic irq_reg;
  logic irq_next;

  // ----------------------------------------------------------------------
  // latch: set on a rising edge, dropped when the raw line falls
  // ----------------------------------------------------------------------
  always_comb begin
    raw_d_next = i_raw;
    held_next  = held_reg;
    if (i_raw && !raw_d_reg) begin
      held_next = 1'b1;
    end else if (!i_raw) begin
      held_next = 1'b0;
    end
    // the select picks latched copy alone or raw gated by it
    irq_next = i_latch_only ? held_next : (i_raw & held_next);
  end

  // registers only
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      raw_d_reg <= 1'b0;
      held_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      raw_d_reg <= raw_d_next;
      held_reg  <= held_next;
      irq_reg   <= irq_next;
    end
  end

  assign o_irq = irq_reg;

  a_latch_drop: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !i_raw |=> !o_irq)
    else $error("latched interrupt outlived its raw line");

endmodule

// ### design/fast_reset_gate_a20_ctrl.sv
/*
  Fast CPU reset and address-line gate control: fast control register,
  gate configuration register, reset pulse sequencer, reset and mask
  combining, and the keyboard/mouse interrupt latches.
  Assumes a 20 MHz clock, synchronous inputs, and a register master that
  issues one-cycle strobes with read data expected one cycle later.
*/
`timescale 1ns/1ps
module fast_reset_gate_a20_ctrl (
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_nrst,
  // register port
  input  wire logic [7:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // keyboard controller side
  input  wire logic                      i_kbc_cpu_reset_n,
  input  wire logic                      i_kbc_gate_port_bit,
  input  wire fast_reset_pkg::irq_pair_t i_raw_irq,
  // CPU side
  output logic                           o_cpu_reset_out_n,
  output logic                           o_addr_line_mask_n,
  output logic                           o_fast_cpu_reset_n,
  output logic                           o_alt_addr_gate,
  output fast_reset_pkg::irq_pair_t      o_irq
);

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  fast_reset_pkg::reg_req_t     req;
  fast_reset_pkg::pulse_state_t state_reg;
  fast_reset_pkg::pulse_state_t state_next;
  logic [7:0]                   ctrl_reg;
  logic [7:0]                   ctrl_next;
  logic [7:0]                   config_reg;
  logic [7:0]                   config_next;
  logic [7:0]                   rdata_reg;
  logic [7:0]                   rdata_next;
  logic [fast_reset_pkg::CNT_W-1:0] cnt_reg;
  logic [fast_reset_pkg::CNT_W-1:0] cnt_next;
  logic                         fast_n_reg;
  logic                         fast_n_next;
  logic                         cpu_rst_reg;
  logic                         cpu_rst_next;
  logic                         mask_reg;
  logic                         mask_next;
  logic                         port_en;
  logic                         hit_ctrl;
  logic                         hit_cfg;
  logic                         arm;
  logic                         kbd_irq_shaped;
  logic                         mouse_irq_shaped;

  localparam logic [fast_reset_pkg::CNT_W-1:0] DELAY_LOAD =
    fast_reset_pkg::CNT_W'(fast_reset_pkg::DELAY_CYCLES - 1);
  localparam logic [fast_reset_pkg::CNT_W-1:0] PULSE_LOAD =
    fast_reset_pkg::CNT_W'(fast_reset_pkg::PULSE_CYCLES - 1);

  // address decode shared by reads and writes
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  assign req      = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign port_en  = config_reg[fast_reset_pkg::PORT_ENABLE_POS];
  // a disabled fast register is not decoded at all
  assign hit_ctrl = addr_hit(req.addr, fast_reset_pkg::FAST_CTRL_OFFSET) && port_en;
  assign hit_cfg  = addr_hit(req.addr, fast_reset_pkg::GATE_CONFIG_OFFSET);

  // ----------------------------------------------------------------------
  // register writes and read data
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_next   = ctrl_reg;
    config_next = config_reg;
    rdata_next  = fast_reset_pkg::READ_ZERO;
    if (req.wr && hit_ctrl) begin
      // only bits 1:0 are live; the rest keep their fixed pattern
      ctrl_next = (req.wdata & fast_reset_pkg::FAST_CTRL_LIVE_MASK)
                | fast_reset_pkg::FAST_CTRL_FIXED;
    end
    if (req.wr && hit_cfg) begin
      config_next = req.wdata;
    end
    if (req.rd && hit_ctrl) begin
      rdata_next = (ctrl_reg & fast_reset_pkg::FAST_CTRL_LIVE_MASK)
                 | fast_reset_pkg::FAST_CTRL_FIXED;
    end else if (req.rd && hit_cfg) begin
      rdata_next = config_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      ctrl_reg   <= fast_reset_pkg::FAST_CTRL_RESET;
      config_reg <= fast_reset_pkg::GATE_CONFIG_RESET;
      rdata_reg  <= fast_reset_pkg::READ_ZERO;
    end else begin
      ctrl_reg   <= ctrl_next;
      config_reg <= config_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // reset pulse sequencer
  // ----------------------------------------------------------------------
  // a pulse is armed only by a 0-to-1 change of the reset bit, and the
  // sequencer waits in hold until software writes the bit back to 0
  assign arm = !ctrl_reg[fast_reset_pkg::RESET_BIT_POS]
             && ctrl_next[fast_reset_pkg::RESET_BIT_POS];

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    fast_n_next = 1'b1;
    unique case (state_reg)
      fast_reset_pkg::ST_IDLE: begin
        if (arm) begin
          state_next = fast_reset_pkg::ST_DELAY;
          cnt_next   = DELAY_LOAD;
        end
      end
      fast_reset_pkg::ST_DELAY: begin
        cnt_next = cnt_reg - fast_reset_pkg::CNT_ONE;
        if (cnt_reg == fast_reset_pkg::CNT_ZERO) begin
          state_next  = fast_reset_pkg::ST_PULSE;
          cnt_next    = PULSE_LOAD;
          fast_n_next = 1'b0;
        end
      end
      fast_reset_pkg::ST_PULSE: begin
        fast_n_next = 1'b0;
        cnt_next    = cnt_reg - fast_reset_pkg::CNT_ONE;
        if (cnt_reg == fast_reset_pkg::CNT_ZERO) begin
          state_next  = fast_reset_pkg::ST_HOLD;
          cnt_next    = fast_reset_pkg::CNT_ZERO;
          fast_n_next = 1'b1;
        end
      end
      fast_reset_pkg::ST_HOLD: begin
        if (!ctrl_reg[fast_reset_pkg::RESET_BIT_POS]) begin
          state_next = fast_reset_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_reg  <= fast_reset_pkg::ST_IDLE;
      cnt_reg    <= fast_reset_pkg::CNT_ZERO;
      fast_n_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      fast_n_reg <= fast_n_next;
    end
  end

  // ----------------------------------------------------------------------
  // combined CPU reset and address mask
  // ----------------------------------------------------------------------
  // computed from the next values so the outputs stay one flop deep
  always_comb begin
    // either source low resets the CPU; polarity bit may invert the pin
    cpu_rst_next = (fast_n_next & i_kbc_cpu_reset_n)
                 ^ config_next[fast_reset_pkg::RESET_POL_POS];
    // the controller side of the gate is its port bit, not a command
    mask_next = i_kbc_gate_port_bit
              | ctrl_next[fast_reset_pkg::GATE_BIT_POS];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cpu_rst_reg <= 1'b0;
      mask_reg    <= 1'b0;
    end else begin
      cpu_rst_reg <= cpu_rst_next;
      mask_reg    <= mask_next;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt latches
  // ----------------------------------------------------------------------
  irq_latch u_kbd_latch (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_raw        (i_raw_irq.kbd_irq),
    .i_latch_only (config_reg[fast_reset_pkg::KBD_LATCH_SEL_POS]),
    .o_irq        (kbd_irq_shaped)
  );

  irq_latch u_mouse_latch (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_raw        (i_raw_irq.mouse_irq),
    .i_latch_only (config_reg[fast_reset_pkg::MOUSE_LATCH_POS]),
    .o_irq        (mouse_irq_shaped)
  );

  // outputs straight from flops
  assign o_rdata            = rdata_reg;
  assign o_fast_cpu_reset_n = fast_n_reg;
  assign o_alt_addr_gate    = ctrl_reg[fast_reset_pkg::GATE_BIT_POS];
  assign o_cpu_reset_out_n  = cpu_rst_reg;
  assign o_addr_line_mask_n = mask_reg;
  assign o_irq              = '{kbd_irq: kbd_irq_shaped, mouse_irq: mouse_irq_shaped};

  // ----------------------------------------------------------------------
  // checker helpers
  // ----------------------------------------------------------------------
  // cycle counts kept apart from the sequencer's own counter, so the
  // timing assertions below would notice a wrong load value
  localparam logic [fast_reset_pkg::CNT_W-1:0] CNT_SAT = '1;
  logic [fast_reset_pkg::CNT_W-1:0] arm_age_reg;
  logic [fast_reset_pkg::CNT_W-1:0] arm_age_next;
  logic [fast_reset_pkg::CNT_W-1:0] low_len_reg;
  logic [fast_reset_pkg::CNT_W-1:0] low_len_next;

  // both saturate so a long quiet spell cannot wrap below a minimum
  always_comb begin
    arm_age_next = arm_age_reg;
    low_len_next = low_len_reg;
    if (arm && state_reg == fast_reset_pkg::ST_IDLE) begin
      arm_age_next = fast_reset_pkg::CNT_ZERO;
    end else if (arm_age_reg != CNT_SAT) begin
      arm_age_next = arm_age_reg + fast_reset_pkg::CNT_ONE;
    end
    if (fast_n_reg) begin
      low_len_next = fast_reset_pkg::CNT_ZERO;
    end else if (low_len_reg != CNT_SAT) begin
      low_len_next = low_len_reg + fast_reset_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      arm_age_reg <= fast_reset_pkg::CNT_ZERO;
      low_len_reg <= fast_reset_pkg::CNT_ZERO;
    end else begin
      arm_age_reg <= arm_age_next;
      low_len_reg <= low_len_next;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_disabled_port_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd && i_addr == fast_reset_pkg::FAST_CTRL_OFFSET && !port_en)
    |=> o_rdata == fast_reset_pkg::READ_ZERO)
    else $error("fast register answered while disabled");

  a_reserved_read_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd && hit_ctrl)
    |=> (o_rdata & ~fast_reset_pkg::FAST_CTRL_LIVE_MASK) == fast_reset_pkg::FAST_CTRL_FIXED)
    else $error("reserved bits read wrong");

  a_gate_follows_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wr && hit_ctrl)
    |=> o_alt_addr_gate == $past(i_wdata[fast_reset_pkg::GATE_BIT_POS]))
    else $error("address gate did not follow write");

  a_no_early_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_reg == fast_reset_pkg::ST_IDLE && arm) |=> o_fast_cpu_reset_n [*8])
    else $error("fast reset fell before the delay");

  a_pulse_long_enough: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(o_fast_cpu_reset_n) |-> state_reg == fast_reset_pkg::ST_PULSE
      && cnt_reg == PULSE_LOAD)
    else $error("fast reset pulse not at full length");

  a_one_pulse_only: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(o_fast_cpu_reset_n) |-> $past(state_reg) == fast_reset_pkg::ST_DELAY)
    else $error("second pulse without rearm");

  a_mask_or_gates: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_addr_line_mask_n == ($past(i_kbc_gate_port_bit) | o_alt_addr_gate))
    else $error("address mask is not the OR of its gates");

  a_reset_and_sources: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (!config_reg[fast_reset_pkg::RESET_POL_POS] && !i_kbc_cpu_reset_n
     && !config_next[fast_reset_pkg::RESET_POL_POS]) |=> !o_cpu_reset_out_n)
    else $error("controller reset did not reach the CPU");

  // measured from the edge that took the arming write
  a_delay_measured: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(o_fast_cpu_reset_n) |-> int'(arm_age_reg) >= fast_reset_pkg::DELAY_CYCLES)
    else $error("fast reset fell sooner than the least delay after arming");

  // a pulse cut short by a system reset is not a fault of the sequencer
  a_pulse_measured: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ($rose(o_fast_cpu_reset_n) && $past(i_nrst))
    |-> int'(low_len_reg) >= fast_reset_pkg::PULSE_CYCLES)
    else $error("fast reset pulse shorter than the least width");

  // the first edge after release still shows reset values, hence the i_nrst guard
  a_reset_polarity: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_nrst |=> o_cpu_reset_out_n == ((o_fast_cpu_reset_n & $past(i_kbc_cpu_reset_n))
      ^ config_reg[fast_reset_pkg::RESET_POL_POS]))
    else $error("CPU reset output is not the combined reset at the chosen polarity");

  a_reset_values: assert property (@(posedge i_sys_clk)
    !i_nrst |=> o_fast_cpu_reset_n && !o_alt_addr_gate)
    else $error("fast reset or address gate wrong after reset");

endmodule

// ### dv/cpu_side_model.sv
/*
  Model of the CPU reset input that the block drives: it counts low
  pulses on the combined reset line and keeps the length of the last one.
  Assumes a synchronous reset line sampled on the system clock.
*/
`timescale 1ns/1ps
module cpu_side_model (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // reset as seen by the CPU
  input  wire logic i_cpu_reset_n,
  // pulse statistics
  output int        o_pulses,
  output int        o_last_low
);
  int run;

  // ----------------------------------------------------------------------
  // pulse counter
  // ----------------------------------------------------------------------
  // a pulse counts when the line comes back high, so a pulse cut by a system reset is lost
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_pulses   <= 0;
      o_last_low <= 0;
      run        <= 0;
    end else if (i_cpu_reset_n !== 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      o_pulses   <= o_pulses + 1;
      o_last_low <= run;
      run        <= 0;
    end
  end
endmodule

// ### dv/fast_reset_gate_a20_ctrl_tb_top.sv
/*
  Self-checking bench for the fast reset and address gate block.
  Assumes the register port answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ps
module fast_reset_gate_a20_ctrl_tb_top;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam int DELAY_MIN = 14000 / 50;
  localparam int PULSE_MIN = 6000 / 50;
  logic                      i_sys_clk = 1'b0;
  logic                      i_nrst;
  logic [7:0]                i_addr;
  logic [7:0]                i_wdata;
  logic                      i_wr;
  logic                      i_rd;
  logic [7:0]                o_rdata;
  logic                      i_kbc_cpu_reset_n;
  logic                      i_kbc_gate_port_bit;
  fast_reset_pkg::irq_pair_t i_raw_irq;
  logic                      o_cpu_reset_out_n;
  logic                      o_addr_line_mask_n;
  logic                      o_fast_cpu_reset_n;
  logic                      o_alt_addr_gate;
  fast_reset_pkg::irq_pair_t o_irq;
  int                        pulses;
  int                        last_low;
  int                        fails = 0;
  int                        n_compared = 0;
  int                        p0;
  int                        n;
  logic [7:0]                d;

  // 20 MHz clock
  always #25 i_sys_clk = ~i_sys_clk;

  fast_reset_gate_a20_ctrl i_fast_reset_gate_a20_ctrl (
    .i_sys_clk          (i_sys_clk),
    .i_nrst             (i_nrst),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .i_kbc_cpu_reset_n  (i_kbc_cpu_reset_n),
    .i_kbc_gate_port_bit(i_kbc_gate_port_bit),
    .i_raw_irq          (i_raw_irq),
    .o_cpu_reset_out_n  (o_cpu_reset_out_n),
    .o_addr_line_mask_n (o_addr_line_mask_n),
    .o_fast_cpu_reset_n (o_fast_cpu_reset_n),
    .o_alt_addr_gate    (o_alt_addr_gate),
    .o_irq              (o_irq)
  );

  cpu_side_model i_cpu_side_model (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_cpu_reset_n(o_cpu_reset_out_n),
    .o_pulses     (pulses),
    .o_last_low   (last_low)
  );

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  // read data is taken in the cycle after the strobe, just past its edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // bounded wait for the fast reset line to reach a level
  task automatic wait_fast(input logic lvl, output int k);
    k = 0;
    while (o_fast_cpu_reset_n !== lvl && k < 1000) begin
      tick(1);
      k++;
    end
    if (k >= 1000) begin
      fails++;
      $display("[FAIL] %0t fast reset wait ran out", $time);
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_nrst              = 1'b0;
    i_addr              = 8'h00;
    i_wdata             = 8'h00;
    i_wr                = 1'b0;
    i_rd                = 1'b0;
    i_kbc_cpu_reset_n   = 1'b1;
    i_kbc_gate_port_bit = 1'b0;
    i_raw_irq           = 2'b00;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    tick(1);
    chk1(o_fast_cpu_reset_n, 1'b1);
    chk1(o_alt_addr_gate, 1'b0);
    chk1(o_addr_line_mask_n, 1'b0);
    // disabled port: reads zero, writes dropped
    rd(8'h92, d);
    chk8(d, 8'h00);
    wr(8'h92, 8'h02);
    wr(8'hF0, 8'h04);
    rd(8'h92, d);
    chk8(d, 8'h24);
    chk1(o_alt_addr_gate, 1'b0);
    rd(8'hF0, d);
    chk8(d, 8'h04);
    rd(8'hA5, d);
    chk8(d, 8'h00);
    // ones into reserved bits must not show
    wr(8'h92, 8'hFE);
    rd(8'h92, d);
    chk8(d, 8'h26);
    chk1(o_alt_addr_gate, 1'b1);
    // mask truth table over both gate sources
    for (int i = 0; i < 4; i++) begin
      wr(8'h92, {6'h00, i[1], 1'b0});
      i_kbc_gate_port_bit <= i[0];
      tick(2);
      chk1(o_addr_line_mask_n, i[0] | i[1]);
    end
    i_kbc_gate_port_bit <= 1'b0;
    // fast reset pulse: delay and width minimums
    p0 = pulses;
    wr(8'h92, 8'h01);
    wait_fast(1'b0, n);
    chk1(n >= DELAY_MIN, 1'b1);
    tick(2);
    chk1(o_cpu_reset_out_n, 1'b0);
    wait_fast(1'b1, n);
    tick(3);
    chk1(pulses - p0 == 1, 1'b1);
    chk1(last_low >= PULSE_MIN, 1'b1);
    rd(8'h92, d);
    chk8(d, 8'h25);
    // writing one again without clearing makes no pulse
    wr(8'h92, 8'h01);
    tick(500);
    chk1(pulses - p0 == 1, 1'b1);
    wr(8'h92, 8'h00);
    wr(8'h92, 8'h01);
    tick(450);
    chk1(pulses - p0 == 2, 1'b1);
    // polarity select and controller reset
    wr(8'hF0, 8'h24);
    tick(2);
    chk1(o_cpu_reset_out_n, 1'b0);
    i_kbc_cpu_reset_n <= 1'b0;
    tick(2);
    chk1(o_cpu_reset_out_n, 1'b1);
    wr(8'hF0, 8'h04);
    tick(2);
    chk1(o_cpu_reset_out_n, 1'b0);
    i_kbc_cpu_reset_n <= 1'b1;
    tick(2);
    chk1(o_cpu_reset_out_n, 1'b1);
    // both latch selects; keyboard alone first catches swapped lines
    for (int s = 0; s < 2; s++) begin
      wr(8'hF0, (s == 1) ? 8'h1C : 8'h04);
      i_raw_irq <= 2'b10;
      tick(2);
      chk8({6'h00, o_irq}, 8'h02);
      i_raw_irq <= 2'b11;
      tick(2);
      chk8({6'h00, o_irq}, 8'h03);
      i_raw_irq <= 2'b00;
      tick(2);
      chk8({6'h00, o_irq}, 8'h00);
    end
    // reset in mid-run with gate and reset bit set
    wr(8'h92, 8'h03);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    tick(1);
    chk1(o_alt_addr_gate, 1'b0);
    chk1(o_fast_cpu_reset_n, 1'b1);
    rd(8'h92, d);
    chk8(d, 8'h00);
    wr(8'hF0, 8'h04);
    rd(8'h92, d);
    chk8(d, 8'h24);
    end_of_test();
  end
endmodule
